// ### shared/tld_defs.vh
// Functional notes
// - Dual select: latches transparent while both low
// - Select rising edge writes decoded data to position
// - Lowest address input is the address LSB
// - Annunciator bit high on, low off
// - Serial input feeds one shift register, high=1
// - Data clock rising edge shifts one bit in
// - Ten-digit serial: eleventh edge resets shifter, control
// - Five-character serial: tenth edge resets shifter, control
// - Write edge with accepted low commits, then resets
// - Display level near supply: shutdown, all common and segment pins high
// - Three commons, segment lines serve three elements
// - Each common active twice per frame, both polarities
// - Off sees one third, on 1.92 times that
// - Ten-digit serial: six data then four address
// - Eight-digit parallel: six data, three address, one select
// - Numeric: four code bits, two annunciator bits
// - Alphanumeric: six-bit code stored three times across 18 elements, not decoded
`ifndef TLD_DEFS_VH
`define TLD_DEFS_VH

// ----------------------------------------------------------------
// Input word layout
// ----------------------------------------------------------------
`define TLD_DATA_BITS 6
`define TLD_CODE_MSB 3
`define TLD_ANN_FIRST 4
`define TLD_ANN_SECOND 5
`define TLD_CNT_W 4
`define TLD_CNT_ZERO 4'h0
`define TLD_CNT_ONE 4'h1

// ----------------------------------------------------------------
// Display organisation
// ----------------------------------------------------------------
`define TLD_NUM_ELEMS 9
`define TLD_ALPHA_ELEMS 18
`define TLD_COMMONS 3

// ----------------------------------------------------------------
// Drive levels, in thirds of the peak voltage above the low end
// ----------------------------------------------------------------
`define TLD_LVL_W 2
`define TLD_LVL_TOP 2'h3
`define TLD_LVL_UPPER 2'h2
`define TLD_LVL_LOWER 2'h1
`define TLD_LVL_BOTTOM 2'h0

// ----------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------
`define TLD_CLK_HZ 100000000
`define TLD_FRAME_HZ 90
`define TLD_PHASES 6
`define TLD_PHASE_CYCLES (`TLD_CLK_HZ / (`TLD_FRAME_HZ * `TLD_PHASES))
`define TLD_PRE_W 20

`endif

// ### core/tld_driver.v
`include "tld_defs.vh"

module tld_driver #(
   parameter SERIAL = 1,
   parameter ALPHA = 0,
   parameter NPOS = 10,
   parameter AW = 4,
   parameter PHASE_CYCLES = `TLD_PHASE_CYCLES
) (
   input wire sys_clk,
   input wire rst,
   input wire select_a_n,
   input wire select_b_n,
   input wire [`TLD_DATA_BITS-1:0] char_bits,
   input wire [AW-1:0] digit_addr,
   input wire data_clock,
   input wire serial_data,
   input wire write_strobe,
   input wire display_level_pin,
   output reg data_accepted,
   output reg [`TLD_LVL_W-1:0] row_drive_first,
   output reg [`TLD_LVL_W-1:0] row_drive_second,
   output reg [`TLD_LVL_W-1:0] row_drive_third,
   output reg [NPOS*((ALPHA ? `TLD_ALPHA_ELEMS : `TLD_NUM_ELEMS)/3)
               *`TLD_LVL_W-1:0] seg_drive
);

   localparam ELEMS = ALPHA ? `TLD_ALPHA_ELEMS : `TLD_NUM_ELEMS;
   localparam LINES = ELEMS / `TLD_COMMONS;
   localparam NB = `TLD_DATA_BITS + AW;
   localparam IW = 6 + `TLD_DATA_BITS + AW;
   localparam [`TLD_CNT_W-1:0] FULL = NB[`TLD_CNT_W-1:0];
   localparam [`TLD_PRE_W-1:0] PRE_LAST =
      PHASE_CYCLES[`TLD_PRE_W-1:0] - 1'b1;
   // One-hot frame phases: three common-high, then three common-low
   localparam [5:0] PH_H1 = 6'h01;
   localparam [5:0] PH_H2 = 6'h02;
   localparam [5:0] PH_H3 = 6'h04;
   localparam [5:0] PH_L1 = 6'h08;
   localparam [5:0] PH_L2 = 6'h10;
   localparam [5:0] PH_L3 = 6'h20;

   // ----------------------------------------------------------------
   // Character decode
   // ----------------------------------------------------------------
   // Numeric: 7 segments plus two annunciators; alphanumeric keeps the
   // code itself in place of the font, since the glyph table is external
   function [`TLD_ALPHA_ELEMS-1:0] tld_decode;
      input [`TLD_DATA_BITS-1:0] code;
      reg [6:0] seg;
      begin
         case (code[`TLD_CODE_MSB:0])
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            4'ha: seg = 7'h40;
            4'hb: seg = 7'h79;
            4'hc: seg = 7'h76;
            4'hd: seg = 7'h38;
            4'he: seg = 7'h73;
            default: seg = 7'h00;
         endcase
         if (ALPHA)
            tld_decode = {code, code, code};
         else
            tld_decode = {9'h000, code[`TLD_ANN_SECOND],
                          code[`TLD_ANN_FIRST], seg};
      end
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Reset to all ones so idle-high strobes give no false edge
   reg [IW-1:0] sync_a;
   reg [IW-1:0] sync_b;
   always @(posedge sys_clk) begin
      if (rst) begin
         sync_a <= {IW{1'b1}};
         sync_b <= {IW{1'b1}};
      end else begin
         sync_a <= {select_a_n, select_b_n, data_clock, serial_data,
                    write_strobe, display_level_pin, char_bits,
                    digit_addr};
         sync_b <= sync_a;
      end
   end

   wire [AW-1:0] s_addr = sync_b[AW-1:0];
   wire [`TLD_DATA_BITS-1:0] s_code = sync_b[AW+`TLD_DATA_BITS-1:AW];
   wire s_shut = sync_b[AW+`TLD_DATA_BITS];
   wire s_wr = sync_b[AW+`TLD_DATA_BITS+1];
   wire s_sdin = sync_b[AW+`TLD_DATA_BITS+2];
   wire s_dclk = sync_b[AW+`TLD_DATA_BITS+3];
   // Single-select variant uses only the first select
   wire s_sel_b = ALPHA ? sync_b[IW-2] : sync_b[IW-1];
   wire s_sel_a = sync_b[IW-1];

   // Previous levels for edge detection
   reg sel_a_q;
   reg sel_b_q;
   reg dclk_q;
   reg wr_q;
   always @(posedge sys_clk) begin
      if (rst) begin
         sel_a_q <= 1'b1;
         sel_b_q <= 1'b1;
         dclk_q <= 1'b1;
         wr_q <= 1'b1;
      end else begin
         sel_a_q <= s_sel_a;
         sel_b_q <= s_sel_b;
         dclk_q <= s_dclk;
         wr_q <= s_wr;
      end
   end

   wire sel_rise = (s_sel_a & ~sel_a_q) | (s_sel_b & ~sel_b_q);
   wire dclk_rise = s_dclk & ~dclk_q;
   wire wr_rise = s_wr & ~wr_q;

   // ----------------------------------------------------------------
   // Parallel input latches
   // ----------------------------------------------------------------
   // Transparent while both selects low; holds once either rises
   reg [`TLD_DATA_BITS-1:0] par_code;
   reg [AW-1:0] par_addr;
   always @(posedge sys_clk) begin
      if (rst) begin
         par_code <= {`TLD_DATA_BITS{1'b0}};
         par_addr <= {AW{1'b0}};
      end else if (!s_sel_a && !s_sel_b) begin
         par_code <= s_code;
         par_addr <= s_addr;
      end
   end

   // ----------------------------------------------------------------
   // Serial shift register and control counter
   // ----------------------------------------------------------------
   // Data bits go in first, so they end at the top; address last
   reg [NB-1:0] shreg;
   reg [`TLD_CNT_W-1:0] bit_cnt;
   always @(posedge sys_clk) begin
      if (rst) begin
         shreg <= {NB{1'b0}};
         bit_cnt <= `TLD_CNT_ZERO;
      end else if (wr_rise) begin
         shreg <= {NB{1'b0}};
         bit_cnt <= `TLD_CNT_ZERO;
      end else if (dclk_rise) begin
         if (bit_cnt == FULL) begin
            shreg <= {NB{1'b0}};
            bit_cnt <= `TLD_CNT_ZERO;
         end else begin
            shreg <= {shreg[NB-2:0], s_sdin};
            bit_cnt <= bit_cnt + `TLD_CNT_ONE;
         end
      end
   end

   // Accepted goes low one clock after a full word sits in the serial shifter
   always @(posedge sys_clk) begin
      if (rst)
         data_accepted <= 1'b1;
      else
         data_accepted <= !(SERIAL && bit_cnt == FULL);
   end

   // ----------------------------------------------------------------
   // Write selection and display memory
   // ----------------------------------------------------------------
   reg wr_en;
   reg [AW-1:0] wr_addr;
   reg [`TLD_DATA_BITS-1:0] wr_code;
   always @* begin
      if (SERIAL) begin
         wr_en = wr_rise && !data_accepted;
         wr_addr = shreg[AW-1:0];
         wr_code = shreg[NB-1:AW];
      end else begin
         wr_en = sel_rise;
         wr_addr = par_addr;
         wr_code = par_code;
      end
   end

   // Contents survive shutdown; only reset clears them
   reg [ELEMS-1:0] pat [0:NPOS-1];
   integer i;
   // Decoder is sized for the widest font; numeric keeps the low part
   wire [`TLD_ALPHA_ELEMS-1:0] dec_word = tld_decode(wr_code);
   always @(posedge sys_clk) begin
      if (rst) begin
         for (i = 0; i < NPOS; i = i + 1)
            pat[i] <= {ELEMS{1'b0}};
      end else if (wr_en && wr_addr < NPOS) begin
         pat[wr_addr] <= dec_word[ELEMS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Frame oscillator
   // ----------------------------------------------------------------
   // Stands still in shutdown, as the real oscillator does
   reg [`TLD_PRE_W-1:0] pre;
   reg [5:0] phase;
   always @(posedge sys_clk) begin
      if (rst) begin
         pre <= {`TLD_PRE_W{1'b0}};
         phase <= PH_H1;
      end else if (!s_shut) begin
         if (pre == PRE_LAST) begin
            pre <= {`TLD_PRE_W{1'b0}};
            case (phase)
               PH_H1: phase <= PH_H2;
               PH_H2: phase <= PH_H3;
               PH_H3: phase <= PH_L1;
               PH_L1: phase <= PH_L2;
               PH_L2: phase <= PH_L3;
               PH_L3: phase <= PH_H1;
               default: phase <= PH_H1;
            endcase
         end else begin
            pre <= pre + {{(`TLD_PRE_W-1){1'b0}}, 1'b1};
         end
      end
   end

   wire pol_high = |phase[2:0];
   wire act1 = phase[0] | phase[3];
   wire act2 = phase[1] | phase[4];
   wire act3 = phase[2] | phase[5];
   wire [1:0] cidx = act1 ? 2'h0 : (act2 ? 2'h1 : 2'h2);

   // Common level: active at the extreme, idle two thirds from it
   function [`TLD_LVL_W-1:0] tld_com_lvl;
      input act;
      input high;
      begin
         if (act)
            tld_com_lvl = high ? `TLD_LVL_TOP : `TLD_LVL_BOTTOM;
         else
            tld_com_lvl = high ? `TLD_LVL_LOWER : `TLD_LVL_UPPER;
      end
   endfunction

   // ----------------------------------------------------------------
   // Output drivers
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst || s_shut) begin
         row_drive_first <= `TLD_LVL_TOP;
         row_drive_second <= `TLD_LVL_TOP;
         row_drive_third <= `TLD_LVL_TOP;
      end else begin
         row_drive_first <= tld_com_lvl(act1, pol_high);
         row_drive_second <= tld_com_lvl(act2, pol_high);
         row_drive_third <= tld_com_lvl(act3, pol_high);
      end
   end

   // On elements see the full peak, off elements one third of it
   wire [NPOS*LINES*`TLD_LVL_W-1:0] seg_lvl;
   genvar p, l;
   generate
      for (p = 0; p < NPOS; p = p + 1) begin : g_pos
         for (l = 0; l < LINES; l = l + 1) begin : g_line
            localparam integer K = (p * LINES + l) * `TLD_LVL_W;
            wire on = pat[p][l*`TLD_COMMONS + cidx];
            assign seg_lvl[K +: `TLD_LVL_W] = pol_high ?
               (on ? `TLD_LVL_BOTTOM : `TLD_LVL_UPPER) :
               (on ? `TLD_LVL_TOP : `TLD_LVL_LOWER);
         end
      end
   endgenerate

   // One process owns the whole segment bus, so each bit has one driver
   always @(posedge sys_clk) begin
      if (rst || s_shut)
         seg_drive <= {(NPOS*LINES){`TLD_LVL_TOP}};
      else
         seg_drive <= seg_lvl;
   end

endmodule // tld_driver

// ### dv/tld_checker.sv
// ------------------------------------------------
// Port checker for the serial numeric driver
// ------------------------------------------------
module tld_checker #(
   parameter NPOS = 10
) (
   input wire sys_clk,
   input wire rst,
   input wire data_clock,
   input wire write_strobe,
   input wire display_level_pin,
   input wire data_accepted,
   input wire [1:0] row_drive_first,
   input wire [1:0] row_drive_second,
   input wire [1:0] row_drive_third,
   input wire [NPOS*6-1:0] seg_drive
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [NPOS*6-1:0] LOW_BITS = {NPOS*3{2'h1}};
   wire hi_ph;
   wire lo_ph;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Phase class taken from the idle commons
   assign hi_ph = row_drive_first == 2'h1 || row_drive_second == 2'h1;
   assign lo_ph = row_drive_first == 2'h2 || row_drive_second == 2'h2;
   a_high_rows: assert property (row_drive_first == 2'h3 && hi_ph
      |-> row_drive_second == 2'h1 && row_drive_third == 2'h1)
      else $error("idle commons wrong in high phase");
   a_low_rows: assert property (row_drive_first == 2'h0
      |-> row_drive_second == 2'h2 && row_drive_third == 2'h2)
      else $error("idle commons wrong in low phase");
   a_shutdown_drive: assert property (display_level_pin [*8]
      |-> row_drive_first == 2'h3 && row_drive_third == 2'h3 && &seg_drive)
      else $error("outputs not at top level in shutdown");
   a_seg_high: assert property (hi_ph |-> (seg_drive & LOW_BITS) == 0)
      else $error("segment level off in high phase");
   a_seg_low: assert property (lo_ph
      |-> (seg_drive & LOW_BITS) == LOW_BITS)
      else $error("segment level off in low phase");
   a_write_commit: assert property ($rose(write_strobe) && !data_accepted
      |-> ##[1:8] data_accepted)
      else $error("accepted not released after write");
   a_extra_edge: assert property ($rose(data_clock) && !data_accepted
      |-> ##[1:8] data_accepted)
      else $error("accepted not released after extra edge");
   a_accept_stays: assert property ((!data_clock && !write_strobe) [*6]
      ##0 !data_accepted |=> !data_accepted)
      else $error("accepted released without cause");
   c_full_word: cover property ($fell(data_accepted));
   c_commit: cover property ($rose(write_strobe) && !data_accepted);
   c_shutdown: cover property (display_level_pin [*8]);
endmodule // tld_checker

// ### dv/tld_host.sv
// ------------------------------------------------
// Host side of the serial link
// ------------------------------------------------
module tld_host (
   input wire sys_clk,
   output logic data_clock,
   output logic serial_data,
   output logic write_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      data_clock = 1'b0;
      serial_data = 1'b0;
      write_strobe = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Word goes out top bit first; clock rests low between frames
   task automatic send(input logic [10:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = w[i];
         wait_cyc(4);
         data_clock = 1'b1;
         wait_cyc(4);
         data_clock = 1'b0;
      end
      // Line is not held after a frame, so it flips
      serial_data = ~serial_data;
      wait_cyc(4);
   endtask
   // Margin before the strobe covers the accepted flag's delay
   task automatic strobe();
      wait_cyc(4);
      write_strobe = 1'b1;
      wait_cyc(6);
      write_strobe = 1'b0;
      wait_cyc(10);
   endtask
endmodule // tld_host

// ### dv/tb.sv
// ------------------------------------------------
// Testbench top
// ------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NPOS = 10;
   logic sys_clk, rst, display_level_pin;
   logic data_clock, serial_data, write_strobe, data_accepted;
   logic [1:0] row_drive_first, row_drive_second, row_drive_third;
   logic [NPOS*6-1:0] seg_drive;
   logic [1:0] exp_ann [NPOS];
   logic sel_a_n, sel_b_n;
   logic [5:0] pins_char;
   logic [3:0] pins_addr;
   int err_total, tests_run;
   tld_driver #(.SERIAL(1), .ALPHA(0), .NPOS(NPOS), .AW(4),
      .PHASE_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst),
      .select_a_n(sel_a_n), .select_b_n(sel_b_n), .char_bits(pins_char),
      .digit_addr(pins_addr), .data_clock(data_clock),
      .serial_data(serial_data), .write_strobe(write_strobe),
      .display_level_pin(display_level_pin),
      .data_accepted(data_accepted), .row_drive_first(row_drive_first),
      .row_drive_second(row_drive_second),
      .row_drive_third(row_drive_third), .seg_drive(seg_drive));
   tld_host host (.sys_clk(sys_clk), .data_clock(data_clock),
      .serial_data(serial_data), .write_strobe(write_strobe));
   task automatic chk(input string what, input logic [1:0] exp,
         input logic [1:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Segment code of an element in a high phase
   function automatic logic [1:0] seg_code(input logic on);
      return on ? 2'h0 : 2'h2;
   endfunction
   function automatic logic [1:0] row_of(input int k);
      return k ? row_drive_third : row_drive_second;
   endfunction
   // Sample each annunciator mid-phase, away from the phase edges
   task automatic check_ann();
      int t;
      for (int k = 0; k < 2; k++) begin
         t = 0;
         while (row_of(k) === 2'h3 && t < 40) begin
            @(posedge sys_clk); #1; t++;
         end
         while (row_of(k) !== 2'h3 && t < 80) begin
            @(posedge sys_clk); #1; t++;
         end
         @(posedge sys_clk); #1;
         chk("active row", 2'h3, row_of(k));
         for (int p = 0; p < NPOS; p++)
            chk("annunciator", seg_code(exp_ann[p][k]),
               seg_drive[(p*3+2)*2 +: 2]);
      end
   endtask
   // ------------------------------------------------
   // Clock, watchdog, main sequence
   // ------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #200us;
      err_total++;
      give_verdict();
   end
   initial begin
      logic [5:0] d;
      logic [3:0] a;
      void'($urandom(32'hd7f1));
      rst = 1'b1;
      display_level_pin = 1'b0;
      sel_a_n = 1'b1;
      sel_b_n = 1'b1;
      pins_char = 6'h00;
      pins_addr = 4'h0;
      err_total = 0;
      tests_run = 0;
      for (int p = 0; p < NPOS; p++) exp_ann[p] = 2'h0;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      // Short frame: accepted stays high, write only resets
      host.send(11'h7f8, 9);
      chk("accepted short", 2'h1, {1'b0, data_accepted});
      host.strobe();
      // Over-long frame: the extra edge clears the word
      host.send(11'h7f1, 11);
      chk("accepted long", 2'h1, {1'b0, data_accepted});
      host.strobe();
      check_ann();
      for (int i = 0; i < 14; i++) begin
         d = 6'($urandom);
         a = (i == 0) ? 4'h9 : (i == 1) ? 4'ha : 4'($urandom);
         host.send({1'b0, d, a}, 10);
         chk("accepted full", 2'h0, {1'b0, data_accepted});
         // Parallel pins carry junk; a serial part must ignore them
         pins_char = 6'($urandom);
         pins_addr = 4'($urandom);
         sel_a_n = 1'b0;
         sel_b_n = 1'b0;
         host.strobe();
         sel_a_n = 1'b1;
         sel_b_n = 1'b1;
         if (a < NPOS) exp_ann[a] = d[5:4];
         chk("accepted after write", 2'h1, {1'b0, data_accepted});
         if (i % 4 == 3) check_ann();
      end
      display_level_pin = 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
      chk("row in shutdown", 2'h3, row_drive_second);
      chk("row first in shutdown", 2'h3, row_drive_first);
      chk("seg in shutdown", 2'h1, {1'b0, &seg_drive});
      display_level_pin = 1'b0;
      check_ann();
      give_verdict();
   end
endmodule // tb
bind tld_driver tld_checker #(.NPOS(NPOS)) u_chk (.sys_clk(sys_clk),
   .rst(rst), .data_clock(data_clock), .write_strobe(write_strobe),
   .display_level_pin(display_level_pin), .data_accepted(data_accepted),
   .row_drive_first(row_drive_first), .row_drive_second(row_drive_second),
   .row_drive_third(row_drive_third), .seg_drive(seg_drive));
